// [core/rtv_pkg.sv]
// Purpose: shared constants and types for the clock value and alarm registers
// Assumes: 16-bit register words, BCD digits stored at their register positions
// Notes: value fields carry no reset value
package rtv_pkg;
   localparam int DW = 16;
   // control word layout
   localparam int CTL_TIME_EN_BIT = 15;
   localparam int CTL_WREN_BIT = 13;
   localparam int CTL_HALF_BIT = 11;
   localparam int CTL_PTR_LSB = 8;
   // alarm config word layout
   localparam int CFG_ALM_EN_BIT = 15;
   localparam int CFG_CHIME_BIT = 14;
   localparam int CFG_MASK_LSB = 10;
   localparam int CFG_PTR_LSB = 8;
   localparam int CFG_RPT_LSB = 0;
   // reset values of control state, and the repeat count wrap value
   localparam logic [1:0] PTR_RESET = 2'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [7:0] RPT_RESET = 8'h00;
   localparam logic [7:0] RPT_WRAP = 8'hff;
   // legal bits of each BCD byte
   localparam logic [7:0] MON_BITS = 8'h1f;
   localparam logic [7:0] DAY_BITS = 8'h3f;
   localparam logic [7:0] HOUR_BITS = 8'h3f;
   localparam logic [7:0] MINUTE_SECOND_VALUE_BITS = 8'h7f;
   // counting ranges in binary
   localparam logic [6:0] SEC_MAX = 7'h3b;
   localparam logic [6:0] HOUR_MAX = 7'h17;
   localparam logic [6:0] WEEKDAY_DIGIT_MAX = 7'h06;
   localparam logic [6:0] MON_MAX = 7'h0c;
   localparam logic [6:0] YEAR_MAX = 7'h63;
   // alarm mask codes
   localparam logic [3:0] MASK_HALF = 4'h0;
   localparam logic [3:0] MASK_LAST = 4'h9;
   // window pointer codes
   typedef enum logic [1:0] {
      RTV_SEL_MINUTE_SECOND_VALUE = 2'b00,
      RTV_SEL_WDHR = 2'b01,
      RTV_SEL_MONTH_DAY_VALUE = 2'b10,
      RTV_SEL_YEAR = 2'b11
   } rtv_sel_t;
   typedef struct packed {
      logic [7:0] yr;
      logic [7:0] mo;
      logic [7:0] dy;
      logic [2:0] wd;
      logic [7:0] hr;
      logic [7:0] mi;
      logic [7:0] se;
      logic [7:0] amo;
      logic [7:0] ady;
      logic [2:0] awd;
      logic [7:0] ahr;
      logic [7:0] ami;
      logic [7:0] ase;
      logic timeEn;
      logic wrEn;
      logic [1:0] tPtr;
      logic almEn;
      logic chime;
      logic [3:0] amask;
      logic [1:0] aPtr;
      logic [7:0] rpt;
      logic secPend;
      logic halfPend;
      logic [15:0] timeRd;
      logic [15:0] almRd;
      logic evt;
      logic pulse;
   } rtv_state_t;
   typedef struct packed {
      logic [31:0] cnt;
      logic half;
      logic halfTick;
      logic secTick;
   } rtv_tick_state_t;
endpackage : rtv_pkg

// [core/rtv_tick_gen.sv]
// Purpose: half-second and second strobes from the core clock
// Assumes: ticksPerSec even and at least 4
// Notes: clear restarts the second, used when seconds are written
`timescale 1ns/10ps
`default_nettype none
module rtv_tick_gen #(
   parameter int TICKS_PER_SEC = 250_000_000
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic clear,
   output logic halfSec,
   output logic halfTick,
   output logic secTick
);
   import rtv_pkg::*;
   localparam logic [31:0] LAST = 32'(TICKS_PER_SEC - 1);
   localparam logic [31:0] MID = 32'(TICKS_PER_SEC / 2 - 1);
   rtv_tick_state_t st_q, st_d;
   if (TICKS_PER_SEC < 4 || (TICKS_PER_SEC % 2) != 0) begin : g_chk
      $error("rtv_tick_gen: TICKS_PER_SEC must be even and at least 4");
   end
   always_comb begin
      st_d = st_q;
      st_d.halfTick = 1'b0;
      st_d.secTick = 1'b0;
      if (clear || !run) begin
         st_d.cnt = 32'h0;
         st_d.half = 1'b0;
      end else if (st_q.cnt == LAST) begin
         st_d.cnt = 32'h0;
         st_d.half = 1'b0;
         st_d.halfTick = 1'b1;
         st_d.secTick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + 32'h1;
         if (st_q.cnt == MID) begin
            st_d.half = 1'b1;
            st_d.halfTick = 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign halfSec = st_q.half;
   assign halfTick = st_q.halfTick;
   assign secTick = st_q.secTick;
endmodule : rtv_tick_gen
`default_nettype wire

// [core/rtv_time_alarm.sv]
// Purpose: calendar time and alarm value registers behind two pointer windows
// Assumes: host accesses are whole 16-bit words, one strobe per access
// Notes: read data appears one cycle after the read strobe
//
// Summary of operation
// RQ1: repeat count holds number of further alarms
// RQ2: each alarm event decrements the repeat count
// RQ3: count stops at zero unless forever-repeat wraps
// RQ4: year holds two BCD digits, upper byte zero
// RQ5: year writes need write enable set
// RQ6: month tens bit 12, ones bits 11-8
// RQ7: time month read-only, day writable
// RQ8: day tens bits 5-4, ones bits 3-0
// RQ9: weekday in bits 10-8, range 0-6
// RQ10: hour tens bits 5-4, ones bits 3-0
// RQ11: minutes upper byte, seconds lower byte, BCD
// RQ12: month/day, weekday/hours writes need write enable
// RQ13: alarm registers mirror time layout, all writable
// RQ14: unimplemented value bits read zero
// RQ15: value fields are not reset
// RQ16: alarm pointer selects pair, decrements to zero
// RQ17: time pointer selects pair, decrements to zero
// RQ18: alarm enable clears after final alarm
// RQ19: time digits advance once per second
// RQ20: masked alarm digits compared against time
`timescale 1ns/10ps
`default_nettype none
module rtv_time_alarm #(
   parameter int TICKS_PER_SEC = 250_000_000
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ctlWr,
   input wire logic [rtv_pkg::DW-1:0] ctlWdata,
   output logic [rtv_pkg::DW-1:0] ctlRdata,
   input wire logic almCfgWr,
   input wire logic [rtv_pkg::DW-1:0] almCfgWdata,
   output logic [rtv_pkg::DW-1:0] almCfgRdata,
   input wire logic timeWinWr,
   input wire logic timeWinRd,
   input wire logic [rtv_pkg::DW-1:0] timeWinWdata,
   output logic [rtv_pkg::DW-1:0] timeWinRdata,
   input wire logic almWinWr,
   input wire logic almWinRd,
   input wire logic [rtv_pkg::DW-1:0] almWinWdata,
   output logic [rtv_pkg::DW-1:0] almWinRdata,
   output logic alarmEvent,
   output logic alarmPulse
);
   import rtv_pkg::*;

   rtv_state_t st_q, st_d;
   logic halfSec;
   logic halfTick;
   logic secTick;
   logic secClear;

   function automatic logic [6:0] bcd2bin(input logic [7:0] b);
      bcd2bin = 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
   endfunction : bcd2bin

   function automatic logic [7:0] bin2bcd(input logic [6:0] v);
      logic [6:0] t;
      t = v / 7'd10;
      bin2bcd = {t[3:0], 4'(v - t * 7'd10)};
   endfunction : bin2bcd

   // returns {carry, next BCD}; wraps to lo past hi
   function automatic logic [8:0] bump(input logic [7:0] b, input logic [6:0] lo, input logic [6:0] hi);
      logic [6:0] v;
      v = bcd2bin(b);
      if (v >= hi) begin
         bump = {1'b1, bin2bcd(lo)};
      end else begin
         bump = {1'b0, bin2bcd(v + 7'd1)};
      end
   endfunction : bump

   // years 00..99, multiples of four are leap years
   function automatic logic leapYear(input logic [7:0] y);
      if (y[4]) begin
         leapYear = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
         leapYear = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
   endfunction : leapYear

   function automatic logic [6:0] daysInMonth(input logic [7:0] m, input logic [7:0] y);
      logic [6:0] mb;
      mb = bcd2bin(m);
      case (mb)
         7'd2: daysInMonth = leapYear(y) ? 7'd29 : 7'd28;
         7'd4, 7'd6, 7'd9, 7'd11: daysInMonth = 7'd30;
         default: daysInMonth = 7'd31;
      endcase
   endfunction : daysInMonth

   // the second restarts when the seconds are written
   assign secClear = timeWinWr && st_q.wrEn && (st_q.tPtr == RTV_SEL_MINUTE_SECOND_VALUE);

   rtv_tick_gen #(
      .TICKS_PER_SEC(TICKS_PER_SEC)
   ) u_tick (
      .clk(clk),
      .rstn(rstn),
      .run(st_q.timeEn),
      .clear(secClear),
      .halfSec(halfSec),
      .halfTick(halfTick),
      .secTick(secTick)
   );

   always_comb begin
      logic [8:0] c;
      logic [3:0] m;
      logic match;
      logic fire;
      c = 9'h0;
      m = st_q.amask;
      match = 1'b0;
      fire = 1'b0;
      st_d = st_q;
      st_d.evt = 1'b0;
      st_d.secPend = secTick;
      st_d.halfPend = halfTick;

      // calendar advance with carry ripple
      if (secTick) begin
         c = bump(st_q.se, 7'd0, SEC_MAX); // RQ19
         st_d.se = c[7:0];
         if (c[8]) begin
            c = bump(st_q.mi, 7'd0, SEC_MAX); // RQ19
            st_d.mi = c[7:0];
            if (c[8]) begin
               c = bump(st_q.hr, 7'd0, HOUR_MAX); // RQ19
               st_d.hr = c[7:0];
               if (c[8]) begin
                  c = bump({5'h0, st_q.wd}, 7'd0, WEEKDAY_DIGIT_MAX); // RQ19
                  st_d.wd = c[2:0];
                  c = bump(st_q.dy, 7'd1, daysInMonth(st_q.mo, st_q.yr)); // RQ19
                  st_d.dy = c[7:0];
                  if (c[8]) begin
                     c = bump(st_q.mo, 7'd1, MON_MAX); // RQ19
                     st_d.mo = c[7:0];
                     if (c[8]) begin
                        c = bump(st_q.yr, 7'd0, YEAR_MAX); // RQ19
                        st_d.yr = c[7:0];
                     end
                  end
               end
            end
         end
      end

      // compared one cycle after the tick, against the advanced time
      match = (m >= 4'h1) && (m <= MASK_LAST) // RQ20
         && (m < 4'h2 || st_q.se[3:0] == st_q.ase[3:0])
         && (m < 4'h3 || st_q.se[6:4] == st_q.ase[6:4])
         && (m < 4'h4 || st_q.mi[3:0] == st_q.ami[3:0])
         && (m < 4'h5 || st_q.mi[6:4] == st_q.ami[6:4])
         && (m < 4'h6 || st_q.hr == st_q.ahr)
         && (m != 4'h7 || st_q.wd == st_q.awd)
         && (m < 4'h8 || st_q.dy == st_q.ady)
         && (m < 4'h9 || st_q.mo == st_q.amo);
      if (m == MASK_HALF) begin
         fire = st_q.almEn && st_q.halfPend; // RQ20
      end else begin
         fire = st_q.almEn && st_q.secPend && match; // RQ20
      end

      // control word; the run bit itself is behind the write enable
      if (ctlWr) begin
         st_d.wrEn = ctlWdata[CTL_WREN_BIT];
         st_d.tPtr = ctlWdata[CTL_PTR_LSB +: 2];
         if (st_q.wrEn) begin
            st_d.timeEn = ctlWdata[CTL_TIME_EN_BIT];
         end
      end

      if (almCfgWr) begin
         st_d.almEn = almCfgWdata[CFG_ALM_EN_BIT];
         st_d.chime = almCfgWdata[CFG_CHIME_BIT];
         st_d.amask = almCfgWdata[CFG_MASK_LSB +: 4];
         st_d.aPtr = almCfgWdata[CFG_PTR_LSB +: 2];
         st_d.rpt = almCfgWdata[CFG_RPT_LSB +: 8];
      end

      // time window; software writes win over the tick in the same cycle
      if (timeWinWr && st_q.wrEn) begin
         case (st_q.tPtr)
            RTV_SEL_MINUTE_SECOND_VALUE: begin
               st_d.mi = timeWinWdata[15:8] & MINUTE_SECOND_VALUE_BITS; // RQ11
               st_d.se = timeWinWdata[7:0] & MINUTE_SECOND_VALUE_BITS; // RQ11
            end
            RTV_SEL_WDHR: begin
               st_d.wd = timeWinWdata[10:8]; // RQ9 RQ12
               st_d.hr = timeWinWdata[7:0] & HOUR_BITS; // RQ10 RQ12
            end
            RTV_SEL_MONTH_DAY_VALUE: begin
               st_d.dy = timeWinWdata[7:0] & DAY_BITS; // RQ7 RQ8 RQ12
            end
            RTV_SEL_YEAR: begin
               st_d.yr = timeWinWdata[7:0]; // RQ4 RQ5
            end
            default: begin
               st_d.yr = st_q.yr;
            end
         endcase
      end

      if (timeWinRd) begin
         case (st_q.tPtr)
            RTV_SEL_MINUTE_SECOND_VALUE: st_d.timeRd = {st_q.mi, st_q.se}; // RQ11 RQ14
            RTV_SEL_WDHR: st_d.timeRd = {5'h0, st_q.wd, st_q.hr}; // RQ9 RQ14
            RTV_SEL_MONTH_DAY_VALUE: st_d.timeRd = {st_q.mo, st_q.dy}; // RQ6 RQ14
            RTV_SEL_YEAR: st_d.timeRd = {8'h00, st_q.yr}; // RQ4 RQ14
            default: st_d.timeRd = 16'h0000;
         endcase
      end

      // any window access walks the pointer down and parks it at zero
      if ((timeWinRd || timeWinWr) && st_q.tPtr != RTV_SEL_MINUTE_SECOND_VALUE) begin
         st_d.tPtr = st_q.tPtr - 2'h1; // RQ17
      end

      // alarm window; the top slot has no storage
      if (almWinWr) begin
         case (st_q.aPtr)
            RTV_SEL_MINUTE_SECOND_VALUE: begin
               st_d.ami = almWinWdata[15:8] & MINUTE_SECOND_VALUE_BITS; // RQ13
               st_d.ase = almWinWdata[7:0] & MINUTE_SECOND_VALUE_BITS; // RQ13
            end
            RTV_SEL_WDHR: begin
               if (st_q.wrEn) begin
                  st_d.awd = almWinWdata[10:8]; // RQ12 RQ13
                  st_d.ahr = almWinWdata[7:0] & HOUR_BITS; // RQ12 RQ13
               end
            end
            RTV_SEL_MONTH_DAY_VALUE: begin
               if (st_q.wrEn) begin
                  st_d.amo = almWinWdata[15:8] & MON_BITS; // RQ12 RQ13
                  st_d.ady = almWinWdata[7:0] & DAY_BITS; // RQ12 RQ13
               end
            end
            default: begin
               st_d.ase = st_d.ase;
            end
         endcase
      end

      if (almWinRd) begin
         case (st_q.aPtr)
            RTV_SEL_MINUTE_SECOND_VALUE: st_d.almRd = {st_q.ami, st_q.ase}; // RQ13 RQ14
            RTV_SEL_WDHR: st_d.almRd = {5'h0, st_q.awd, st_q.ahr}; // RQ13 RQ14
            RTV_SEL_MONTH_DAY_VALUE: st_d.almRd = {st_q.amo, st_q.ady}; // RQ13 RQ14
            default: st_d.almRd = 16'h0000; // RQ16
         endcase
      end

      if ((almWinRd || almWinWr) && st_q.aPtr != RTV_SEL_MINUTE_SECOND_VALUE) begin
         st_d.aPtr = st_q.aPtr - 2'h1; // RQ16
      end

      // event acts on top of a same-cycle config write so none is lost
      if (fire) begin
         st_d.evt = 1'b1;
         st_d.pulse = ~st_q.pulse;
         if (st_d.rpt != RPT_RESET) begin
            st_d.rpt = st_d.rpt - 8'h01; // RQ1 RQ2
         end else if (st_d.chime) begin
            st_d.rpt = RPT_WRAP; // RQ3
         end else begin
            st_d.almEn = 1'b0; // RQ3 RQ18
         end
      end
   end

   // only control state is reset; time and alarm values keep whatever they hold
   always_ff @(posedge clk) begin
      st_q <= st_d;
      if (!rstn) begin
         st_q.timeEn <= 1'b0;
         st_q.wrEn <= 1'b0;
         st_q.tPtr <= PTR_RESET;
         st_q.almEn <= 1'b0;
         st_q.chime <= 1'b0;
         st_q.amask <= MASK_RESET;
         st_q.aPtr <= PTR_RESET;
         st_q.rpt <= RPT_RESET;
         st_q.secPend <= 1'b0;
         st_q.halfPend <= 1'b0;
         st_q.timeRd <= 16'h0000;
         st_q.almRd <= 16'h0000;
         st_q.evt <= 1'b0;
         st_q.pulse <= 1'b0;
      end // RQ15
   end

   assign ctlRdata = {st_q.timeEn, 1'b0, st_q.wrEn, 1'b0, halfSec, 1'b0, st_q.tPtr, 8'h00};
   assign almCfgRdata = {st_q.almEn, st_q.chime, st_q.amask, st_q.aPtr, st_q.rpt};
   assign timeWinRdata = st_q.timeRd;
   assign almWinRdata = st_q.almRd;
   assign alarmEvent = st_q.evt;
   assign alarmPulse = st_q.pulse;
endmodule : rtv_time_alarm
`default_nettype wire

// [test/rtv_time_alarm_assertions.sv]
// Purpose: port checks for rtv_time_alarm
// Assumes: one clock domain, sync reset
// Notes: value fields stay unknown until written
`timescale 1ns/10ps
`default_nettype none
module rtv_time_alarm_assertions #(parameter int TICKS_PER_SEC = 8) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ctlWr,
   input wire logic [15:0] ctlWdata,
   input wire logic [15:0] ctlRdata,
   input wire logic almCfgWr,
   input wire logic [15:0] almCfgWdata,
   input wire logic [15:0] almCfgRdata,
   input wire logic timeWinWr,
   input wire logic timeWinRd,
   input wire logic [15:0] timeWinWdata,
   input wire logic [15:0] timeWinRdata,
   input wire logic almWinWr,
   input wire logic almWinRd,
   input wire logic [15:0] almWinWdata,
   input wire logic [15:0] almWinRdata,
   input wire logic alarmEvent,
   input wire logic alarmPulse
);
   import rtv_pkg::*;
   wire logic [1:0] tp = ctlRdata[9:8];
   wire logic [1:0] ap = almCfgRdata[9:8];
   wire logic [7:0] rpt = almCfgRdata[7:0];
   wire logic en = almCfgRdata[15];
   wire logic chm = almCfgRdata[14];
   // bits that no slot implements, per pointer code
   function automatic logic [15:0] hole(input logic a, input logic [1:0] p);
      case (p)
         2'h0: return 16'h8080;
         2'h1: return 16'hf8c0;
         2'h2: return 16'he0c0;
         default: return a ? 16'hffff : 16'hff00;
      endcase
   endfunction : hole
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // zero minus one is the chime wrap, so one figure covers both
   AST_RPT_STEP: assert property (!$past(almCfgWr) && $changed(rpt) |->
      rpt == $past(rpt) - 8'h01 && (alarmEvent || $past(alarmEvent))) else $error("repeat count bad step");
   AST_RPT_HOLD: assert property (!$past(almCfgWr) && $past(rpt) == 8'h00 && !$past(chm) |-> rpt == 8'h00)
      else $error("repeat count left zero");
   AST_EN_CLEAR: assert property (!$past(almCfgWr) && $fell(en) |-> $past(rpt) == 8'h00 && !$past(chm))
      else $error("alarm enable cleared early");
   AST_TIME_HOLES: assert property ($past(timeWinRd) && !$past(ctlWr) |->
      (timeWinRdata & hole(1'b0, $past(tp))) == 16'h0000) else $error("time slot hole not zero");
   AST_ALM_HOLES: assert property ($past(almWinRd) && !$past(almCfgWr) |->
      (almWinRdata & hole(1'b1, $past(ap))) == 16'h0000) else $error("alarm slot hole not zero");
   AST_TPTR_DEC: assert property ((timeWinRd || timeWinWr) && !ctlWr |=>
      tp == ($past(tp) == 2'h0 ? 2'h0 : $past(tp) - 2'h1)) else $error("time pointer bad step");
   AST_APTR_DEC: assert property ((almWinRd || almWinWr) && !almCfgWr |=>
      ap == ($past(ap) == 2'h0 ? 2'h0 : $past(ap) - 2'h1)) else $error("alarm pointer bad step");
   AST_PULSE_TOGGLE: assert property ($changed(alarmPulse) |-> alarmEvent || $past(alarmEvent))
      else $error("alarm pulse moved without event");
   cover property ($rose(alarmEvent));
   cover property ($fell(en));
   cover property ($past(rpt) == 8'h00 && rpt == 8'hff);
endmodule : rtv_time_alarm_assertions
bind rtv_time_alarm rtv_time_alarm_assertions #(.TICKS_PER_SEC(TICKS_PER_SEC)) i_chk (.clk(clk), .rstn(rstn),
   .ctlWr(ctlWr), .ctlWdata(ctlWdata), .ctlRdata(ctlRdata), .almCfgWr(almCfgWr), .almCfgWdata(almCfgWdata),
   .almCfgRdata(almCfgRdata), .timeWinWr(timeWinWr), .timeWinRd(timeWinRd), .timeWinWdata(timeWinWdata),
   .timeWinRdata(timeWinRdata), .almWinWr(almWinWr), .almWinRd(almWinRd), .almWinWdata(almWinWdata),
   .almWinRdata(almWinRdata), .alarmEvent(alarmEvent), .alarmPulse(alarmPulse));
`default_nettype wire

// [test/rtv_tb.sv]
// Purpose: self-checking bench for rtv_time_alarm
// Assumes: second shortened to 8 clocks
// Notes: month of the time slot is never written, so it is masked
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rtv_pkg::*;
   localparam int TPS = 8;
   typedef struct packed {logic a; logic [1:0] p; logic [15:0] w; logic [15:0] m; logic [15:0] e;} rtv_row_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ctlWr = 1'b0, almCfgWr = 1'b0, timeWinWr = 1'b0, timeWinRd = 1'b0, almWinWr = 1'b0, almWinRd = 1'b0;
   logic [15:0] ctlWdata = 16'h0000, almCfgWdata = 16'h0000, timeWinWdata = 16'h0000, almWinWdata = 16'h0000;
   logic [15:0] ctlRdata, almCfgRdata, timeWinRdata, almWinRdata;
   logic alarmEvent, alarmPulse;
   int bad_count = 0;
   int cmp_count = 0;
   int n;
   int j;
   rtv_row_t rows [8] = '{
      '{1'b0, 2'h3, 16'hff99, 16'hffff, 16'h0099}, '{1'b0, 2'h2, 16'h1f31, 16'h00ff, 16'h0031},
      '{1'b0, 2'h1, 16'hfee3, 16'hffff, 16'h0623}, '{1'b0, 2'h0, 16'hd9d9, 16'hffff, 16'h5959},
      '{1'b1, 2'h2, 16'hf231, 16'hffff, 16'h1231}, '{1'b1, 2'h1, 16'h0106, 16'hffff, 16'h0106},
      '{1'b1, 2'h0, 16'h0000, 16'hffff, 16'h0000}, '{1'b1, 2'h3, 16'hffff, 16'hffff, 16'h0000}};
   always #2 clk = ~clk;
   rtv_time_alarm #(.TICKS_PER_SEC(TPS)) i_dut (.clk(clk), .rstn(rstn), .ctlWr(ctlWr), .ctlWdata(ctlWdata),
      .ctlRdata(ctlRdata), .almCfgWr(almCfgWr), .almCfgWdata(almCfgWdata), .almCfgRdata(almCfgRdata),
      .timeWinWr(timeWinWr), .timeWinRd(timeWinRd), .timeWinWdata(timeWinWdata), .timeWinRdata(timeWinRdata),
      .almWinWr(almWinWr), .almWinRd(almWinRd), .almWinWdata(almWinWdata), .almWinRdata(almWinRdata),
      .alarmEvent(alarmEvent), .alarmPulse(alarmPulse));
   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", s, e, g);
         bad_count++;
      end
   endtask : chk
   task stop_test;
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // all tasks start and end at a falling edge
   task cfg(input logic a, input logic [15:0] d);
      ctlWr = !a;
      almCfgWr = a;
      ctlWdata = d;
      almCfgWdata = d;
      @(negedge clk);
      ctlWr = 1'b0;
      almCfgWr = 1'b0;
   endtask : cfg
   task acc(input logic a, input logic wr, input logic [15:0] d);
      {timeWinWr, timeWinRd, almWinWr, almWinRd} = {!a && wr, !a && !wr, a && wr, a && !wr};
      timeWinWdata = d;
      almWinWdata = d;
      @(negedge clk);
      {timeWinWr, timeWinRd, almWinWr, almWinRd} = 4'h0;
   endtask : acc
   task rd(input logic a, input logic [15:0] m, input logic [15:0] e);
      acc(a, 1'b0, 16'h0000);
      chk("window", e & m, (a ? almWinRdata : timeWinRdata) & m);
   endtask : rd
   // time side keeps write enable on and the clock stopped; alarm side writes the config with the alarm off and mask 8
   task ptr(input logic a, input logic [1:0] p);
      cfg(a, {6'h08, p, 8'h00});
   endtask : ptr
   task wait_evt;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (alarmEvent !== 1'b1 && n < 40);
      if (alarmEvent !== 1'b1) begin
         bad_count++;
         stop_test();
      end
   endtask : wait_evt
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      chk("ctl", 16'h0000, ctlRdata);
      chk("cfg", 16'h0000, almCfgRdata);
      chk("event", 16'h0000, {14'h0000, alarmEvent, alarmPulse});
      for (int i = 0; i < 8; i++) begin
         ptr(rows[i].a, rows[i].p);
         acc(rows[i].a, 1'b1, rows[i].w);
         ptr(rows[i].a, rows[i].p);
         rd(rows[i].a, rows[i].m, rows[i].e);
      end
      // locked writes must still walk the pointer
      for (int i = 0; i < 3; i++) begin
         cfg(1'b0, {6'h00, rows[i].p, 8'h00});
         acc(1'b0, 1'b1, 16'h0000);
         chk("ptr", {6'h00, rows[i].p - 2'h1, 8'h00}, ctlRdata);
         ptr(1'b0, rows[i].p);
         rd(1'b0, rows[i].m, rows[i].e);
      end
      ptr(1'b0, 2'h3);
      timeWinRd = 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         j = i < 4 ? i : 3;
         chk("walk", rows[j].e & rows[j].m, timeWinRdata & rows[j].m);
      end
      timeWinRd = 1'b0;
      ptr(1'b0, 2'h1);
      acc(1'b0, 1'b1, 16'h0305);
      acc(1'b0, 1'b1, 16'h5959);
      cfg(1'b0, 16'ha000);
      repeat (TPS + 4) @(negedge clk);
      ptr(1'b0, 2'h1);
      rd(1'b0, 16'hffff, 16'h0306);
      rd(1'b0, 16'hffff, 16'h0000);
      cfg(1'b1, 16'h8402);
      cfg(1'b0, 16'ha000);
      n = 0;
      repeat (60) begin
         @(negedge clk);
         if (alarmEvent === 1'b1) n++;
      end
      chk("alarms", 16'h0003, 16'(n));
      chk("cfg", 16'h0400, almCfgRdata);
      chk("pulse", 16'h0001, {15'h0000, alarmPulse});
      cfg(1'b1, 16'hc400);
      wait_evt();
      @(negedge clk);
      chk("wrap", 16'hc4ff, almCfgRdata);
      wait_evt();
      @(negedge clk);
      chk("step", 16'hc4fe, almCfgRdata);
      // half-second mask with one repeat: two events, then the enable drops
      cfg(1'b1, 16'h8001);
      n = 0;
      repeat (20) begin
         @(negedge clk);
         if (alarmEvent === 1'b1) n++;
      end
      chk("half", 16'h0002, 16'(n));
      chk("cfg", 16'h0000, almCfgRdata);
      // reserved mask codes never match
      cfg(1'b1, 16'hac00);
      n = 0;
      repeat (20) begin
         @(negedge clk);
         if (alarmEvent === 1'b1) n++;
      end
      chk("reserved", 16'h0000, 16'(n));
      stop_test();
   end
endmodule : tb
`default_nettype wire
